// ==== dv/pacr_host.sv ====
// Host controller model issuing single-byte control-port transfers
`timescale 1ns/10ps

module pacr_host (
  input wire logic ref_clk,
  output pacr_pkg::pacr_req_s ctrl_req,
  input wire logic [7:0] ctrl_rdata,
  input wire logic ctrl_rvalid,
  input wire logic ctrl_page_hit
);
  import pacr_pkg::*;

  initial ctrl_req = '0;

  // Idle address and data are scrambled so nothing leans on stale bus values
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic h, output logic v);
    @(posedge ref_clk);
    #1 ctrl_req = '{w, r, a, d};
    @(posedge ref_clk);
    #1 q = ctrl_rdata;
    h = ctrl_page_hit;
    v = ctrl_rvalid;
    ctrl_req = '{1'b0, 1'b0, 8'($urandom), 8'($urandom)};
  endtask
endmodule

// ==== dv/pacr_regs_sva.sv ====
// Port-level assertions for the register bank
`timescale 1ns/10ps

module pacr_regs_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pacr_pkg::pacr_req_s ctrl_req,
  input wire logic [7:0] ctrl_rdata,
  input wire logic ctrl_rvalid,
  input wire logic ctrl_page_hit,
  input wire logic primary_port_role,
  input wire logic [3:0] standard_max_channel_select,
  input wire logic auto_main_rate_source,
  input wire logic [7:0] page_select,
  input wire logic biquad_runtime_update_en,
  input wire pacr_pkg::pacr_port_dir_s primary_port_dir,
  input wire logic clock_autodetect_en,
  input wire logic [3:0] max_channel_enable,
  input wire logic rate_converter_enable,
  input wire logic rate_autodetect_en,
  input wire logic main_rate_source
);
  import pacr_pkg::*;

  logic [7:0] a;
  logic [7:0] d;
  logic p1;
  assign a = ctrl_req.addr;
  assign d = ctrl_req.wdata;
  // Write that lands on this bank's page
  assign p1 = ctrl_req.wr_en && page_select == PACR_BANK_PAGE;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  rd_answer_a: assert property (ctrl_req.rd_en |=> ctrl_rvalid)
    else $error("read not answered");
  page_miss_a: assert property (ctrl_req.rd_en && a != 8'h00 && page_select != PACR_BANK_PAGE
    |=> !ctrl_page_hit && ctrl_rdata == 8'h00) else $error("other page answered");
  page_wr_a: assert property (ctrl_req.wr_en && a == 8'h00 |=> page_select == $past(d))
    else $error("page not stored");
  biquad_wr_a: assert property (p1 && a == 8'h03 |=> biquad_runtime_update_en == $past(d[0]))
    else $error("biquad enable wrong");
  port_override_a: assert property (p1 && a == 8'h0d |=>
    clock_autodetect_en == !($past(d[7]) || $past(d[6])) &&
    primary_port_dir.fsync_is_output == ($past(d[7]) ^ primary_port_role)) else $error("override");
  int_fsync_a: assert property (p1 && a == 8'h0d |=> primary_port_dir.use_internal_fsync ==
    (primary_port_dir.fsync_is_output && $past(d[2]))) else $error("frame sync select");
  chan_mask_a: assert property (p1 && a == 8'h0e |=> max_channel_enable ==
    ($past(d[7]) ? $past(d[6:3]) : standard_max_channel_select)) else $error("channel mask");
  conv_ctrl_a: assert property (p1 && a == 8'h17 |=> rate_converter_enable == $past(d[7]) &&
    rate_autodetect_en == !$past(d[6])) else $error("converter control");
  main_rate_a: assert property (p1 && a == 8'h18 |=> main_rate_source ==
    ($past(d[7]) ? $past(d[6]) : auto_main_rate_source)) else $error("main rate source");
  reset_state_a: assert property (disable iff (1'b0) sys_rst |=> page_select == 8'h00 &&
    !ctrl_rvalid && clock_autodetect_en && rate_autodetect_en) else $error("reset state");

  cover property (p1 && a == 8'h0d && d[7]);
  cover property (ctrl_req.rd_en && ctrl_req.wr_en);
  cover property (ctrl_req.rd_en && page_select != PACR_BANK_PAGE && a != 8'h00);
endmodule

bind pacr_regs pacr_regs_sva u_sva (.ref_clk, .sys_rst, .ctrl_req, .ctrl_rdata, .ctrl_rvalid,
  .ctrl_page_hit, .primary_port_role, .standard_max_channel_select, .auto_main_rate_source,
  .page_select, .biquad_runtime_update_en, .primary_port_dir, .clock_autodetect_en,
  .max_channel_enable, .rate_converter_enable, .rate_autodetect_en, .main_rate_source);

// ==== dv/tb.sv ====
// Randomised self-checking bench for the register bank
`timescale 1ns/10ps

module tb;
  import pacr_pkg::*;

  localparam logic [7:0] OFS [6] = '{8'h00, 8'h03, 8'h0d, 8'h0e, 8'h17, 8'h18};
  localparam logic [7:0] MSK [6] = '{8'hff, 8'h01, 8'hc6, 8'hf8, 8'hc0, 8'hff};

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic primary_port_role = 1'b0;
  logic secondary_port_role = 1'b0;
  logic [3:0] standard_max_channel_select = 4'h0;
  logic auto_main_rate_source = 1'b0;
  pacr_req_s ctrl_req;
  logic [7:0] ctrl_rdata, page_select;
  logic ctrl_rvalid, ctrl_page_hit, biquad_runtime_update_en, clock_autodetect_en;
  logic rate_converter_enable, rate_autodetect_en, main_rate_source;
  pacr_port_dir_s primary_port_dir, secondary_port_dir;
  logic [3:0] max_channel_enable;
  pacr_ratio_s ratio_m, ratio_n;
  logic [39:0] got;
  logic [7:0] sh [6];
  int n_mismatch = 0;
  int checked = 0;

  always #2.5 ref_clk = ~ref_clk;

  assign got = {7'h0, page_select, biquad_runtime_update_en, primary_port_dir, secondary_port_dir,
    clock_autodetect_en, max_channel_enable, rate_converter_enable, rate_autodetect_en,
    main_rate_source, ratio_m, ratio_n};

  pacr_regs u_dut (.ref_clk, .sys_rst, .ctrl_req, .ctrl_rdata, .ctrl_rvalid, .ctrl_page_hit,
    .primary_port_role, .secondary_port_role, .standard_max_channel_select,
    .auto_main_rate_source, .page_select, .biquad_runtime_update_en, .primary_port_dir,
    .secondary_port_dir, .clock_autodetect_en, .max_channel_enable, .rate_converter_enable,
    .rate_autodetect_en, .main_rate_source, .ratio_m, .ratio_n);

  pacr_host u_host (.ref_clk, .ctrl_req, .ctrl_rdata, .ctrl_rvalid, .ctrl_page_hit);

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [4:0] rat(input logic [2:0] c);
    logic rs;
    rs = (c == 3'h5) || (c == 3'h7);
    return {(c != 3'h0) && !rs, rs, rs ? 3'h0 : c};
  endfunction

  function automatic logic [2:0] dir(input logic ov, input logic role, input logic fi);
    return {role, ov ^ role, (ov ^ role) & fi};
  endfunction

  function automatic logic [39:0] expv();
    return {7'h0, sh[0], sh[1][0], dir(sh[2][7], primary_port_role, sh[2][2]),
      dir(sh[2][6], secondary_port_role, sh[2][1]), !(sh[2][7] | sh[2][6]),
      sh[3][7] ? sh[3][6:3] : standard_max_channel_select, sh[4][7], !sh[4][6],
      sh[5][7] ? sh[5][6] : auto_main_rate_source, rat(sh[5][5:3]), rat(sh[5][2:0])};
  endfunction

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One transfer; a read beside a write sees the value from before it
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [7:0] e;
    logic h;
    logic v;
    logic eh;
    e = 8'h00;
    eh = 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (OFS[k] == a && (k == 0 || sh[0] == PACR_BANK_PAGE)) begin
        e = sh[k];
        eh = 1'b1;
        if (w) sh[k] = d & MSK[k];
      end
    end
    u_host.xfer(w, r, a, d, q, h, v);
    chk("answer", r ? {e, eh, 1'b1} : 10'h0, {q, h, v});
    chk("decoded", expv(), got);
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    logic [7:0] d;
    sh = '{default: 8'h00};
    void'($urandom(62));
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    acc(1'b0, 1'b1, 8'h00, 8'h00);
    acc(1'b1, 1'b0, 8'h17, 8'hc0);
    acc(1'b0, 1'b1, 8'h17, 8'h00);
    acc(1'b1, 1'b1, 8'h00, PACR_BANK_PAGE);
    for (int i = 1; i < 6; i++) begin
      acc(1'b1, 1'b1, OFS[i], MSK[i]);
      acc(1'b0, 1'b1, OFS[i], 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 1'b0, 8'h18, {2'b10, 3'(c), 3'(7 - c)});
    end
    for (int i = 0; i < 300; i++) begin
      {primary_port_role, secondary_port_role, standard_max_channel_select} = 6'($urandom);
      auto_main_rate_source = 1'($urandom);
      k = $urandom % 7;
      d = (k == 6) ? 8'($urandom) : 8'($urandom) & MSK[k % 6];
      if (k == 0) d = ($urandom % 3 == 0) ? 8'hff : PACR_BANK_PAGE;
      acc(1'($urandom), 1'($urandom), (k == 6) ? 8'h40 | 8'($urandom) : OFS[k], d);
    end
    #1 sys_rst = 1'b1;
    @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    sh = '{default: 8'h00};
    chk("reset state", expv(), got);
    acc(1'b0, 1'b1, 8'h00, 8'h00);
    summarize();
  end

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule

// ==== verilog/pacr_pkg.sv ====
// Constants and carrier types for the page-1 audio configuration register bank
package pacr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PACR_OFS_PAGE_SELECT = 8'h00;
  localparam logic [7:0] PACR_OFS_FILTER_UPDATE = 8'h03;
  localparam logic [7:0] PACR_OFS_SERIAL_CLOCK = 8'h0d;
  localparam logic [7:0] PACR_OFS_DYN_CHANNEL = 8'h0e;
  localparam logic [7:0] PACR_OFS_RATE_CONV0 = 8'h17;
  localparam logic [7:0] PACR_OFS_RATE_CONV1 = 8'h18;

  // Page that this bank answers on
  localparam logic [7:0] PACR_BANK_PAGE = 8'h01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PACR_RST_PAGE_SELECT = 8'h00;
  localparam logic [7:0] PACR_RST_FILTER_UPDATE = 8'h00;
  localparam logic [7:0] PACR_RST_SERIAL_CLOCK = 8'h00;
  localparam logic [7:0] PACR_RST_DYN_CHANNEL = 8'h00;
  localparam logic [7:0] PACR_RST_RATE_CONV0 = 8'h00;
  localparam logic [7:0] PACR_RST_RATE_CONV1 = 8'h00;
  localparam logic [7:0] PACR_RD_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Writable-bit masks; reserved positions store nothing
  // ----------------------------------------------------------------
  localparam logic [7:0] PACR_WMASK_PAGE_SELECT = 8'hff;
  localparam logic [7:0] PACR_WMASK_FILTER_UPDATE = 8'h01;
  localparam logic [7:0] PACR_WMASK_SERIAL_CLOCK = 8'hc6;
  localparam logic [7:0] PACR_WMASK_DYN_CHANNEL = 8'hf8;
  localparam logic [7:0] PACR_WMASK_RATE_CONV0 = 8'hc0;
  localparam logic [7:0] PACR_WMASK_RATE_CONV1 = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PACR_BIT_BIQUAD_UPDATE = 0;
  localparam int PACR_BIT_PRI_OVERRIDE = 7;
  localparam int PACR_BIT_SEC_OVERRIDE = 6;
  localparam int PACR_BIT_PRI_INT_FSYNC = 2;
  localparam int PACR_BIT_SEC_INT_FSYNC = 1;
  localparam int PACR_BIT_FORCE_MASK = 7;
  localparam int PACR_MASK_MSB = 6;
  localparam int PACR_MASK_LSB = 3;
  localparam int PACR_BIT_CONV_EN = 7;
  localparam int PACR_BIT_AUTODET_DIS = 6;
  localparam int PACR_BIT_MAIN_MANUAL = 7;
  localparam int PACR_BIT_MAIN_SOURCE = 6;
  localparam int PACR_RATIO_M_MSB = 5;
  localparam int PACR_RATIO_M_LSB = 3;
  localparam int PACR_RATIO_N_MSB = 2;
  localparam int PACR_RATIO_N_LSB = 0;

  // Ratio field codes
  localparam logic [2:0] PACR_RATIO_AUTO = 3'h0;
  localparam logic [2:0] PACR_RATIO_RSVD_A = 3'h5;
  localparam logic [2:0] PACR_RATIO_RSVD_B = 3'h7;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pacr_req_s;

  typedef struct packed {
    logic bclk_is_output;
    logic fsync_is_output;
    logic use_internal_fsync;
  } pacr_port_dir_s;

  typedef struct packed {
    logic manual;
    logic reserved;
    logic [2:0] value;
  } pacr_ratio_s;

  typedef enum logic [1:0] {
    PACR_RD_IDLE_ST = 2'b00,
    PACR_RD_HIT_ST = 2'b01,
    PACR_RD_MISS_ST = 2'b10
  } pacr_rd_state_e;

endpackage

// ==== verilog/pacr_regs.sv ====
// Page-1 audio configuration register bank with decoded control outputs
`timescale 1ns/10ps

module pacr_regs
  import pacr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pacr_pkg::pacr_req_s ctrl_req,
  output logic [7:0] ctrl_rdata,
  output logic ctrl_rvalid,
  output logic ctrl_page_hit,
  input wire logic primary_port_role,
  input wire logic secondary_port_role,
  input wire logic [3:0] standard_max_channel_select,
  input wire logic auto_main_rate_source,
  output logic [7:0] page_select,
  output logic biquad_runtime_update_en,
  output pacr_pkg::pacr_port_dir_s primary_port_dir,
  output pacr_pkg::pacr_port_dir_s secondary_port_dir,
  output logic clock_autodetect_en,
  output logic [3:0] max_channel_enable,
  output logic rate_converter_enable,
  output logic rate_autodetect_en,
  output logic main_rate_source,
  output pacr_pkg::pacr_ratio_s ratio_m,
  output pacr_pkg::pacr_ratio_s ratio_n
);
  import pacr_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Role 1 is controller; the override flips only the frame sync direction, the bit clock follows the role
  function automatic pacr_port_dir_s port_dir(input logic role, input logic ovr,
                                              input logic int_fs);
    pacr_port_dir_s d;
    d.bclk_is_output = role;
    d.fsync_is_output = ovr ? ~role : role;
    // Internal frame sync only matters while this end makes the frame sync
    d.use_internal_fsync = d.fsync_is_output & int_fs;
    return d;
  endfunction

  function automatic pacr_ratio_s ratio_decode(input logic [2:0] code);
    pacr_ratio_s r;
    r.manual = (code != PACR_RATIO_AUTO);
    r.reserved = (code == PACR_RATIO_RSVD_A) || (code == PACR_RATIO_RSVD_B);
    // Reserved codes are passed on as auto so the converter never sees them
    r.value = r.reserved ? PACR_RATIO_AUTO : code;
    if (r.reserved) begin
      r.manual = 1'b0;
    end
    return r;
  endfunction

  // Masked write keeps reserved positions at zero whatever software sends
  function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
    return data & mask;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic [7:0] filter_reg;
  logic [7:0] filter_next;
  logic [7:0] sclk_reg;
  logic [7:0] sclk_next;
  logic [7:0] dynch_reg;
  logic [7:0] dynch_next;
  logic [7:0] conv0_reg;
  logic [7:0] conv0_next;
  logic [7:0] conv1_reg;
  logic [7:0] conv1_next;
  logic bank_sel;

  // Offset zero is visible on every page; the rest only on this bank's page
  assign bank_sel = (page_reg == PACR_BANK_PAGE);

  always_comb begin
    page_next = page_reg;
    filter_next = filter_reg;
    sclk_next = sclk_reg;
    dynch_next = dynch_reg;
    conv0_next = conv0_reg;
    conv1_next = conv1_reg;
    if (ctrl_req.wr_en) begin
      if (ctrl_req.addr == PACR_OFS_PAGE_SELECT) begin
        page_next = masked(ctrl_req.wdata, PACR_WMASK_PAGE_SELECT);
      end else if (bank_sel) begin
        case (ctrl_req.addr)
          PACR_OFS_FILTER_UPDATE: begin
            filter_next = masked(ctrl_req.wdata, PACR_WMASK_FILTER_UPDATE);
          end
          PACR_OFS_SERIAL_CLOCK: begin
            sclk_next = masked(ctrl_req.wdata, PACR_WMASK_SERIAL_CLOCK);
          end
          PACR_OFS_DYN_CHANNEL: begin
            dynch_next = masked(ctrl_req.wdata, PACR_WMASK_DYN_CHANNEL);
          end
          PACR_OFS_RATE_CONV0: begin
            conv0_next = masked(ctrl_req.wdata, PACR_WMASK_RATE_CONV0);
          end
          PACR_OFS_RATE_CONV1: begin
            conv1_next = masked(ctrl_req.wdata, PACR_WMASK_RATE_CONV1);
          end
          default: begin
            // Unmapped offsets ignore the write
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      page_reg <= PACR_RST_PAGE_SELECT;
      filter_reg <= PACR_RST_FILTER_UPDATE;
      sclk_reg <= PACR_RST_SERIAL_CLOCK;
      dynch_reg <= PACR_RST_DYN_CHANNEL;
      conv0_reg <= PACR_RST_RATE_CONV0;
      conv1_reg <= PACR_RST_RATE_CONV1;
    end else begin
      page_reg <= page_next;
      filter_reg <= filter_next;
      sclk_reg <= sclk_next;
      dynch_reg <= dynch_next;
      conv0_reg <= conv0_next;
      conv1_reg <= conv1_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is registered: one cycle from request to answer
  pacr_rd_state_e rd_state_reg;
  pacr_rd_state_e rd_state_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rd_state_next = PACR_RD_IDLE_ST;
    rdata_next = PACR_RD_IDLE;
    if (ctrl_req.rd_en) begin
      rd_state_next = PACR_RD_HIT_ST;
      if (ctrl_req.addr == PACR_OFS_PAGE_SELECT) begin
        rdata_next = page_reg;
      end else if (bank_sel) begin
        case (ctrl_req.addr)
          PACR_OFS_FILTER_UPDATE: rdata_next = filter_reg;
          PACR_OFS_SERIAL_CLOCK: rdata_next = sclk_reg;
          PACR_OFS_DYN_CHANNEL: rdata_next = dynch_reg;
          PACR_OFS_RATE_CONV0: rdata_next = conv0_reg;
          PACR_OFS_RATE_CONV1: rdata_next = conv1_reg;
          default: rd_state_next = PACR_RD_MISS_ST;
        endcase
      end else begin
        rd_state_next = PACR_RD_MISS_ST;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_state_reg <= PACR_RD_IDLE_ST;
      rdata_reg <= PACR_RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    case (rd_state_reg)
      PACR_RD_HIT_ST: begin
        ctrl_rvalid = 1'b1;
        ctrl_page_hit = 1'b1;
      end
      PACR_RD_MISS_ST: begin
        ctrl_rvalid = 1'b1;
        ctrl_page_hit = 1'b0;
      end
      default: begin
        ctrl_rvalid = 1'b0;
        ctrl_page_hit = 1'b0;
      end
    endcase
  end

  // Misses read as zero, as do reserved bits, since they never store
  assign ctrl_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic pri_ovr;
  logic sec_ovr;

  assign pri_ovr = sclk_reg[PACR_BIT_PRI_OVERRIDE];
  assign sec_ovr = sclk_reg[PACR_BIT_SEC_OVERRIDE];

  assign page_select = page_reg;
  assign biquad_runtime_update_en = filter_reg[PACR_BIT_BIQUAD_UPDATE];

  assign primary_port_dir = port_dir(primary_port_role, pri_ovr,
                                     sclk_reg[PACR_BIT_PRI_INT_FSYNC]);
  assign secondary_port_dir = port_dir(secondary_port_role, sec_ovr,
                                       sclk_reg[PACR_BIT_SEC_INT_FSYNC]);

  // Either override makes the clock roles fixed, so detection must stay off
  assign clock_autodetect_en = ~(pri_ovr | sec_ovr);

  assign max_channel_enable = dynch_reg[PACR_BIT_FORCE_MASK]
                            ? dynch_reg[PACR_MASK_MSB:PACR_MASK_LSB]
                            : standard_max_channel_select;

  assign rate_converter_enable = conv0_reg[PACR_BIT_CONV_EN];
  assign rate_autodetect_en = ~conv0_reg[PACR_BIT_AUTODET_DIS];

  assign main_rate_source = conv1_reg[PACR_BIT_MAIN_MANUAL]
                          ? conv1_reg[PACR_BIT_MAIN_SOURCE]
                          : auto_main_rate_source;

  assign ratio_m = ratio_decode(conv1_reg[PACR_RATIO_M_MSB:PACR_RATIO_M_LSB]);
  assign ratio_n = ratio_decode(conv1_reg[PACR_RATIO_N_MSB:PACR_RATIO_N_LSB]);

endmodule
